// File: shared/ata_tf_pkg.sv
// Constants and types shared by the task-file register block
package ata_tf_pkg;
    // ============
    // Register indices on the task-file port
    localparam logic [2:0] IDX_ERROR   = 3'h0; // Write: features
    localparam logic [2:0] IDX_SCOUNT  = 3'h1;
    localparam logic [2:0] IDX_SNUM    = 3'h2;
    localparam logic [2:0] IDX_DEVHEAD = 3'h3;
    localparam logic [2:0] IDX_STATUS  = 3'h4; // Write: command
    localparam logic [2:0] IDX_ALTSTAT = 3'h5; // Write: device control
    localparam logic [2:0] IDX_DRVADDR = 3'h6;
    // ============
    // Field positions
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_SEEK  = 4;
    localparam int ST_XREQ  = 3;
    localparam int ST_REV   = 1;
    localparam int ST_ERR   = 0;
    localparam int ER_CRC   = 7;
    localparam int ER_UNC   = 6;
    localparam int ER_SECTOR_ID_MISSING  = 4;
    localparam int ER_COMMAND_ABORTED_FLAG  = 2;
    localparam int ER_TK0   = 1;
    localparam int DH_LBA   = 6;
    localparam int DC_HOB   = 7;
    localparam int DC_SOFT_RESET_BIT  = 2;
    localparam int DC_NIEN  = 1;
    // ============
    // Values after reset and fixed encodings
    localparam logic [7:0] STATUS_RST  = 8'h50;
    localparam logic [7:0] SCOUNT_RST  = 8'h01;
    localparam logic [7:0] SNUM_RST    = 8'h01;
    localparam logic [7:0] DEVHEAD_RST = 8'h00;
    localparam logic [7:0] DIAG_OK     = 8'h01;
    localparam logic [7:0] DH_FIXED    = 8'hA0; // Bits 7 and 5 forced to one on device/head writes
    localparam logic [7:0] ERR_MASK    = 8'h56; // Reportable media errors
    localparam logic [7:0] FEAT_REVERT = 8'hCC;
    localparam logic [16:0] SECT_ZERO_28 = 17'h00100;
    localparam logic [16:0] SECT_ZERO_48 = 17'h10000;
    // ============
    // Power modes
    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_IDLE,
        PM_STANDBY,
        PM_SLEEP
    } power_mode_t;
endpackage

// File: verilog/ata_taskfile_registers.sv
// Device-side task-file register set
// ============
// Overview of operation
// - drive address bit 7 never driven
// - write gate bit low during media write
// - head bits are complement of head
// - unit 0 select bit low unless asleep; unit 1 bit always high
// - bit 6 selects LBA; unit bit ignored
// - completion updates head or LBA 24-27
// - error register valid; diagnostic code after reset
// - link CRC fault sets error bit 7
// - media error bits reported; bits 5,3 zero
// - mark, fault, fixed-data bits always zero
// - zero count means 256 or 65536
// - count zero on success, remainder on failure
// - sector number holds LBA low byte
// - status read acknowledges interrupt; refreshed on events
// - busy set: reads return status
// - ready low at power-on and after error
// - seek bit tracks seeks, held after error
// - error bit set on failure, cleared on command
// - link/soft reset aborts, flushes, reinitialises registers
// - reset moves sleep to standby; power-on idle, or standby when strapped
// - parameter revert on link/soft reset only when enabled; always at power-on
// - reset sets busy; status 50h once diagnosis ends, counts 01h
module ata_taskfile_registers #(
    parameter logic [7:0] SET_FEATURES_OP = 8'h00 // Opcode, no default known
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_n_in,
    input  wire logic [2:0]               reg_index_in,
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    input  wire logic [7:0]               reg_wdata_in,
    output logic      [7:0]               reg_rdata_out,
    output logic      [7:0]               reg_rdata_oe_n_out,
    output logic                          intrq_out,
    output logic                          cmd_valid_out,
    output logic      [7:0]               cmd_code_out,
    output logic      [7:0]               features_out,
    output logic                          lba_mode_out,
    output logic      [16:0]              sector_total_out,
    output logic      [7:0]               start_sector_out,
    output logic      [7:0]               start_sector_prev_out,
    output logic      [3:0]               start_head_out,
    input  wire logic                     addr48_in,
    input  wire logic                     cmd_done_in,
    input  wire logic [3:0]               done_head_in,
    input  wire logic [7:0]               done_sector_in,
    input  wire logic [7:0]               done_count_in,
    input  wire logic [7:0]               done_err_in,
    input  wire logic                     error_event_in,
    input  wire logic                     crc_error_in,
    input  wire logic                     write_active_in,
    input  wire logic                     seek_start_in,
    input  wire logic                     seek_settled_in,
    input  wire logic                     index_pulse_in,
    input  wire logic                     xfer_request_in,
    input  wire logic                     core_ready_in,
    input  wire logic                     link_reset_in,
    input  wire logic                     diag_done_in,
    input  wire logic [7:0]               diag_code_in,
    input  wire logic                     pwr_up_standby_in,
    input  wire logic                     pm_req_in,
    input  wire ata_tf_pkg::power_mode_t  pm_mode_in,
    output ata_tf_pkg::power_mode_t       power_mode_out,
    output logic                          abort_host_out,
    output logic                          flush_abort_out,
    output logic                          restore_defaults_out
);
    // ============
    // State
    logic [7:0] scount_q, scount_prev_q, snum_q, snum_prev_q;
    logic [7:0] devhead_q, features_q, error_q, devctl_q;
    logic       busy_q, err_q, err_hold_q, intr_pend_q;
    logic       crc_seen_q, dsc_live_q, dsc_frozen_q, dsc_hold_q;
    logic       ready_q, xreq_q, rev_q, wgate_q;
    logic       revert_en_q, por_init_q;
    ata_tf_pkg::power_mode_t pm_q;

    // ============
    // Decode of host accesses
    logic       soft_reset_bit_now, soft_reset_bit_rise, iface_reset;
    logic       wr_ok, cmd_accept, status_rd, low_power;
    logic       dsc_now, device_ready;
    logic [7:0] status_val, drvaddr_val, read_val;
    logic [15:0] count16;
    logic [16:0] total_val;

    // Soft reset held while the control bit is one
    assign soft_reset_bit_now  = devctl_q[ata_tf_pkg::DC_SOFT_RESET_BIT];
    assign soft_reset_bit_rise = reg_wr_in && reg_index_in == ata_tf_pkg::IDX_ALTSTAT
                       && reg_wdata_in[ata_tf_pkg::DC_SOFT_RESET_BIT] && !soft_reset_bit_now;
    assign iface_reset = link_reset_in | soft_reset_bit_rise;
    // Busy blocks all writes except device control, so reset still lands
    assign wr_ok = reg_wr_in && !soft_reset_bit_now && !link_reset_in
                   && (!busy_q || reg_index_in == ata_tf_pkg::IDX_ALTSTAT);
    assign cmd_accept = wr_ok && reg_index_in == ata_tf_pkg::IDX_STATUS
                        && !xreq_q;
    assign status_rd = reg_rd_in && reg_index_in == ata_tf_pkg::IDX_STATUS;
    assign low_power = pm_q == ata_tf_pkg::PM_STANDBY
                       || pm_q == ata_tf_pkg::PM_SLEEP;

    // Seek bit: frozen after error, forced high in standby or sleep
    assign dsc_now = dsc_hold_q ? dsc_frozen_q
                   : (low_power | dsc_live_q);
    assign device_ready = ready_q & ~err_hold_q;

    // Status image; fault and fixed-data bits are constant zero
    always_comb begin
        status_val = 8'h00;
        status_val[ata_tf_pkg::ST_BUSY]  = busy_q;
        status_val[ata_tf_pkg::ST_READY] = device_ready;
        status_val[ata_tf_pkg::ST_SEEK]  = dsc_now;
        status_val[ata_tf_pkg::ST_XREQ]  = xreq_q;
        status_val[ata_tf_pkg::ST_REV]   = rev_q;
        status_val[ata_tf_pkg::ST_ERR]   = err_q;
    end

    // Drive address: complemented head, device 0 only, bit 7 undriven
    always_comb begin
        drvaddr_val = {1'b0, ~wgate_q, ~devhead_q[3:0],
                       1'b1, pm_q == ata_tf_pkg::PM_SLEEP};
    end

    // Read multiplexer; busy turns every read into a status read
    always_comb begin
        read_val = 8'h00;
        if (busy_q) begin
            read_val = status_val;
        end else begin
            case (reg_index_in)
                ata_tf_pkg::IDX_ERROR:   read_val = error_q;
                ata_tf_pkg::IDX_SCOUNT:
                    read_val = devctl_q[ata_tf_pkg::DC_HOB] ?
                               scount_prev_q : scount_q;
                ata_tf_pkg::IDX_SNUM:
                    read_val = devctl_q[ata_tf_pkg::DC_HOB] ?
                               snum_prev_q : snum_q;
                ata_tf_pkg::IDX_DEVHEAD: read_val = devhead_q;
                ata_tf_pkg::IDX_STATUS:  read_val = status_val;
                ata_tf_pkg::IDX_ALTSTAT: read_val = status_val;
                ata_tf_pkg::IDX_DRVADDR: read_val = drvaddr_val;
                default:                 read_val = 8'h00;
            endcase
        end
    end

    // Zero count stands for the full range of the addressing kind
    always_comb begin
        count16 = {scount_prev_q, scount_q};
        if (addr48_in) begin
            total_val = (count16 == 16'h0000) ? ata_tf_pkg::SECT_ZERO_48
                                               : {1'b0, count16};
        end else begin
            total_val = (scount_q == 8'h00) ? ata_tf_pkg::SECT_ZERO_28
                                             : {9'h000, scount_q};
        end
    end

    // ============
    // Read data port, registered
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out      <= 8'h00;
            reg_rdata_oe_n_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= read_val;
            // Bit 7 of drive address is left floating
            reg_rdata_oe_n_out <= (!busy_q &&
                reg_index_in == ata_tf_pkg::IDX_DRVADDR) ?
                8'h80 : 8'h00;
        end
    end

    // ============
    // Device control and features
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            devctl_q   <= 8'h00;
            features_q <= 8'h00;
        end else begin
            if (reg_wr_in && reg_index_in == ata_tf_pkg::IDX_ALTSTAT) begin
                devctl_q <= reg_wdata_in;
            end else if (cmd_accept) begin
                devctl_q[ata_tf_pkg::DC_HOB] <= 1'b0; // Command drops HOB
            end
            if (wr_ok && reg_index_in == ata_tf_pkg::IDX_ERROR) begin
                features_q <= reg_wdata_in;
            end
        end
    end

    // ============
    // Address registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scount_q      <= ata_tf_pkg::SCOUNT_RST;
            scount_prev_q <= 8'h00;
            snum_q        <= ata_tf_pkg::SNUM_RST;
            snum_prev_q   <= 8'h00;
            devhead_q     <= ata_tf_pkg::DEVHEAD_RST;
        end else if (iface_reset || soft_reset_bit_now) begin
            scount_q      <= ata_tf_pkg::SCOUNT_RST;
            scount_prev_q <= 8'h00;
            snum_q        <= ata_tf_pkg::SNUM_RST;
            snum_prev_q   <= 8'h00;
            devhead_q     <= ata_tf_pkg::DEVHEAD_RST;
        end else if (cmd_done_in && busy_q) begin
            scount_q  <= done_count_in;
            snum_q    <= done_sector_in;
            devhead_q <= {devhead_q[7:4], done_head_in};
        end else if (wr_ok) begin
            // Each count or sector number write pushes the old byte into the previous copy
            case (reg_index_in)
                ata_tf_pkg::IDX_SCOUNT: begin
                    scount_prev_q <= scount_q;
                    scount_q      <= reg_wdata_in;
                end
                ata_tf_pkg::IDX_SNUM: begin
                    snum_prev_q <= snum_q;
                    snum_q      <= reg_wdata_in;
                end
                ata_tf_pkg::IDX_DEVHEAD: begin
                    devhead_q <= reg_wdata_in | ata_tf_pkg::DH_FIXED;
                end
                default: ;
            endcase
        end
    end

    // ============
    // Command hand-off to the core
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_valid_out         <= 1'b0;
            cmd_code_out          <= 8'h00;
            features_out          <= 8'h00;
            lba_mode_out          <= 1'b0;
            sector_total_out      <= 17'h00000;
            start_sector_out      <= 8'h00;
            start_sector_prev_out <= 8'h00;
            start_head_out        <= 4'h0;
        end else begin
            cmd_valid_out <= cmd_accept;
            if (cmd_accept) begin
                cmd_code_out          <= reg_wdata_in;
                features_out          <= features_q;
                lba_mode_out <= devhead_q[ata_tf_pkg::DH_LBA];
                sector_total_out      <= total_val;
                start_sector_out      <= snum_q;
                start_sector_prev_out <= snum_prev_q;
                start_head_out        <= devhead_q[3:0];
            end
        end
    end

    // ============
    // Busy flag
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b1; // Power-on diagnosis pending
        end else if (iface_reset || soft_reset_bit_now || cmd_accept) begin
            busy_q <= 1'b1;
        end else if (busy_q && (cmd_done_in || diag_done_in)) begin
            busy_q <= 1'b0;
        end
    end

    // ============
    // Error register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            error_q    <= ata_tf_pkg::DIAG_OK;
            crc_seen_q <= 1'b0;
        end else begin
            // A fault in the accept cycle still counts
            crc_seen_q <= crc_error_in
                          | (crc_seen_q & ~cmd_accept & ~iface_reset);
            if (busy_q && diag_done_in) begin
                error_q <= diag_code_in;
            end else if (busy_q && cmd_done_in) begin
                error_q <= (done_err_in & ata_tf_pkg::ERR_MASK)
                           | {crc_seen_q | crc_error_in, 7'h00};
            end else if (crc_error_in) begin
                error_q[ata_tf_pkg::ER_CRC] <= 1'b1;
            end
        end
    end

    // ============
    // Error status bit, ready hold and seek hold
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_q        <= 1'b0;
            err_hold_q   <= 1'b0;
            dsc_hold_q   <= 1'b0;
            dsc_frozen_q <= 1'b0;
        end else begin
            if (iface_reset || cmd_accept) begin
                err_q <= 1'b0;
            end else if (busy_q && cmd_done_in) begin
                err_q <= |(done_err_in & ata_tf_pkg::ERR_MASK)
                         | crc_seen_q | crc_error_in;
            end
            // Error sets win over the status read that clears them
            if (busy_q && (error_event_in || (cmd_done_in &&
                |(done_err_in & ata_tf_pkg::ERR_MASK)))) begin
                err_hold_q <= 1'b1;
                if (!dsc_hold_q) begin
                    dsc_hold_q   <= 1'b1;
                    dsc_frozen_q <= dsc_now;
                end
            end else if (status_rd || iface_reset) begin
                err_hold_q <= 1'b0;
                dsc_hold_q <= 1'b0;
            end
        end
    end

    // ============
    // Live status inputs sampled into flops
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_q    <= 1'b0;
            dsc_live_q <= 1'b1;
            xreq_q     <= 1'b0;
            rev_q      <= 1'b0;
            wgate_q    <= 1'b0;
        end else begin
            ready_q <= core_ready_in;
            xreq_q  <= xfer_request_in;
            rev_q   <= index_pulse_in;
            wgate_q <= write_active_in;
            if (seek_start_in) begin
                dsc_live_q <= 1'b0;
            end else if (seek_settled_in) begin
                dsc_live_q <= 1'b1;
            end
        end
    end

    // ============
    // Interrupt pending; enable gating adds one cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            intr_pend_q <= 1'b0;
            intrq_out   <= 1'b0;
        end else begin
            if (busy_q && (cmd_done_in || diag_done_in)) begin
                intr_pend_q <= 1'b1;
            end else if (status_rd || iface_reset) begin
                intr_pend_q <= 1'b0;
            end
            intrq_out <= intr_pend_q && !devctl_q[ata_tf_pkg::DC_NIEN];
        end
    end

    // ============
    // Reset actions toward the core
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            abort_host_out       <= 1'b0;
            flush_abort_out      <= 1'b0;
            restore_defaults_out <= 1'b0;
            revert_en_q          <= 1'b0;
            por_init_q           <= 1'b1;
        end else begin
            abort_host_out  <= iface_reset;
            flush_abort_out <= iface_reset;
            // Power-on always restores; interface resets only if enabled
            restore_defaults_out <= por_init_q
                                    | (iface_reset & revert_en_q);
            por_init_q <= 1'b0;
            if (cmd_accept && reg_wdata_in == SET_FEATURES_OP
                && features_q == ata_tf_pkg::FEAT_REVERT) begin
                revert_en_q <= 1'b1;
            end
        end
    end

    // ============
    // Power mode; strap caught on first edge after release
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pm_q <= ata_tf_pkg::PM_IDLE;
        end else if (por_init_q) begin
            pm_q <= pwr_up_standby_in ? ata_tf_pkg::PM_STANDBY
                                      : ata_tf_pkg::PM_IDLE;
        end else if (iface_reset) begin
            if (pm_q == ata_tf_pkg::PM_SLEEP) begin
                pm_q <= ata_tf_pkg::PM_STANDBY;
            end
        end else if (pm_req_in) begin
            pm_q <= pm_mode_in;
        end
    end

    assign power_mode_out = pm_q;
endmodule

// File: testbench/ata_tf_checker.sv
// Checker of the task-file register block, bound to its top ports
module ata_tf_checker (
    input wire logic                    clk_sys_in,
    input wire logic                    rst_n_in,
    input wire logic [2:0]              reg_index_in,
    input wire logic                    reg_rd_in,
    input wire logic [7:0]              reg_rdata_out,
    input wire logic                    intrq_out,
    input wire logic                    cmd_valid_out,
    input wire logic [16:0]             sector_total_out,
    input wire logic                    addr48_in,
    input wire logic                    cmd_done_in,
    input wire logic                    error_event_in,
    input wire logic                    link_reset_in,
    input wire logic                    pm_req_in,
    input wire logic                    abort_host_out,
    input wire logic                    flush_abort_out,
    input wire ata_tf_pkg::power_mode_t power_mode_out
);
    // ============
    // One clock domain, all disabled by the power-on reset
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Sector totals: zero means a full block, never nothing
    count_nonzero_a: assert property (
        cmd_valid_out |-> sector_total_out != 17'h00000)
        else $error("zero sector total");
    count_narrow_a: assert property (
        cmd_valid_out && !$past(addr48_in) |-> sector_total_out <= 17'h00100)
        else $error("narrow count above 256");
    // Status read with no new event drops the interrupt
    ack_clear_a: assert property (
        reg_rd_in && reg_index_in == 3'h4 && !cmd_done_in && !error_event_in
        ##1 !cmd_done_in && !error_event_in |-> ##[1:2] !intrq_out)
        else $error("interrupt kept after status read");
    status_zero_a: assert property (
        reg_rd_in && reg_index_in inside {3'h4, 3'h5}
        |=> !reg_rdata_out[5] && !reg_rdata_out[2])
        else $error("fault or fixed bit set");
    // Link reset aborts host side and flushes, both on the next cycle
    abort_host_a: assert property (
        link_reset_in |=> abort_host_out)
        else $error("no host abort");
    flush_abort_a: assert property (
        link_reset_in |=> flush_abort_out)
        else $error("no flush abort");
    sleep_wake_a: assert property (
        link_reset_in && power_mode_out == ata_tf_pkg::PM_SLEEP
        |-> ##[1:3] power_mode_out == ata_tf_pkg::PM_STANDBY)
        else $error("sleep not left for standby");
    keep_mode_a: assert property (
        link_reset_in && power_mode_out != ata_tf_pkg::PM_SLEEP && !pm_req_in
        |=> power_mode_out == $past(power_mode_out))
        else $error("mode changed by reset");
endmodule

// File: testbench/ata_tf_host_model.sv
// Host adapter model driving the task-file port through tasks
module ata_tf_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic       xfer_request_in,
    output logic      [2:0] reg_index_in,
    output logic            reg_wr_in,
    output logic            reg_rd_in,
    output logic      [7:0] reg_wdata_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet bus at start
    initial {reg_index_in, reg_wr_in, reg_rd_in, reg_wdata_in} = '0;
    // Write; data flips after release so a stale byte never looks valid
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        @(posedge clk_sys_in);
        while (i == 3'h4 && xfer_request_in)
            @(posedge clk_sys_in);
        #1;
        reg_index_in = i;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr_in = 1'b0;
        reg_wdata_in = ~d;
    endtask
    // Read; the answer is registered at the taking edge
    task automatic rd(input logic [2:0] i, output logic [7:0] d);
        @(posedge clk_sys_in);
        #1;
        reg_index_in = i;
        reg_rd_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_rd_in = 1'b0;
        d = reg_rdata_out;
    endtask
    // Poll alternate status so no interrupt is acknowledged
    task automatic wait_idle(output logic [7:0] s);
        s = 8'hFF;
        for (int k = 0; k < 64 && s[7] !== 1'b0; k++)
            rd(3'h5, s);
    endtask
    // Reset bit must stand 5 us, 625 cycles
    task automatic soft_reset();
        wr(3'h5, 8'h04);
        repeat (625) @(posedge clk_sys_in);
        wr(3'h5, 8'h00);
    endtask
endmodule

// File: testbench/ata_taskfile_registers_bench.sv
// Self-checking bench of the task-file register block
`define CHK(a, e) begin n_compared++; \
    if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module ata_taskfile_registers_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, intrq_out, l, wa;
    logic cmd_valid_out, lba_mode_out, addr48_in, cmd_done_in, pm_req_in;
    logic error_event_in, crc_error_in, write_active_in, seek_start_in;
    logic seek_settled_in, index_pulse_in, xfer_request_in, core_ready_in;
    logic link_reset_in, diag_done_in, pwr_up_standby_in, abort_host_out;
    logic flush_abort_out, restore_defaults_out;
    logic [2:0] reg_index_in;
    logic [3:0] start_head_out, done_head_in, h;
    logic [7:0] reg_wdata_in, reg_rdata_out, reg_rdata_oe_n_out, r, c, s, e;
    logic [7:0] cmd_code_out, features_out, start_sector_out, diag_code_in;
    logic [7:0] start_sector_prev_out, done_sector_in, done_count_in;
    logic [7:0] done_err_in;
    logic [16:0] sector_total_out;
    ata_tf_pkg::power_mode_t pm_mode_in, power_mode_out;
    int bad_count, n_compared;
    ata_taskfile_registers ata_taskfile_registers_inst (.*);
    ata_tf_host_model ata_tf_host_model_inst (.*);
    // Free-running system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // Short helpers for pulses and register cycles
    task automatic pulse(ref logic p);
        p = 1'b1;
        @(posedge clk_sys_in);
        #1 p = 1'b0;
    endtask
    task automatic rd(input logic [2:0] i);
        ata_tf_host_model_inst.rd(i, r);
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        ata_tf_host_model_inst.wr(i, d);
    endtask
    function automatic logic [16:0] total(logic [7:0] n, logic w);
        return n != 8'h00 ? {9'h000, n} : (w ? 17'h10000 : 17'h00100);
    endfunction
    // Diagnosis ends, then status, counts, device/head and error hold their reset values
    task automatic boot(input string t);
        diag_code_in = ata_tf_pkg::DIAG_OK;
        pulse(diag_done_in);
        ata_tf_host_model_inst.wait_idle(r);
        rd(3'h4);
        `CHK(r, 8'h50)
        rd(3'h1);
        `CHK(r, 8'h01)
        rd(3'h2);
        `CHK(r, 8'h01)
        rd(3'h3);
        `CHK(r, 8'h00)
        rd(3'h0);
        `CHK(r, ata_tf_pkg::DIAG_OK)
        $display("test done: %s", t);
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    // Main sequence; seek and strap inputs stay tied low
    initial begin
        {rst_n_in, addr48_in, cmd_done_in, error_event_in, crc_error_in} = '0;
        {write_active_in, seek_start_in, seek_settled_in, index_pulse_in} = '0;
        {xfer_request_in, link_reset_in, diag_done_in, pm_req_in} = '0;
        {pwr_up_standby_in, done_head_in, done_sector_in, done_count_in} = '0;
        {done_err_in, diag_code_in, bad_count, n_compared} = '0;
        core_ready_in = 1'b1;
        pm_mode_in = ata_tf_pkg::PM_IDLE;
        void'($urandom(32'h96F6));
        repeat (6) @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        boot("power-on");
        `CHK(power_mode_out, ata_tf_pkg::PM_IDLE)
        for (int k = 0; k < 4; k++) begin
            h = 4'($urandom);
            wa = 1'($urandom);
            write_active_in = wa;
            wr(3'h3, {3'b101, 1'($urandom), h});
            rd(3'h6);
            `CHK(r[6:0], {~wa, ~h, 2'b10})
            `CHK(reg_rdata_oe_n_out, 8'h80)
        end
        $display("test done: drive address");
        // Zero counts in both widths, errors on odd passes
        for (int k = 0; k < 4; k++) begin
            c = (k < 2) ? 8'h00 : 8'($urandom);
            {s, h, l} = {8'($urandom), 4'($urandom), k[1]};
            e = k[0] ? ((8'($urandom) & ata_tf_pkg::ERR_MASK) | 8'h04) : '0;
            addr48_in = (k == 1);
            wr(3'h1, 8'h00);
            wr(3'h1, c);
            wr(3'h2, s);
            wr(3'h3, {1'b1, l, 2'b10, h});
            wr(3'h4, 8'($urandom));
            `CHK(cmd_valid_out, 1'b1)
            `CHK(sector_total_out, total(c, k == 1))
            `CHK({lba_mode_out, start_head_out, start_sector_out}, {l, h, s})
            rd(3'h6);
            `CHK(r[7], 1'b1)
            `CHK(intrq_out, 1'b0)
            done_err_in = e;
            done_count_in = k[0] ? 8'($urandom) : 8'h00;
            {done_head_in, done_sector_in} = {4'($urandom), 8'($urandom)};
            {error_event_in, cmd_done_in} = {k[0], 1'b1};
            @(posedge clk_sys_in);
            #1 {error_event_in, cmd_done_in} = 2'b00;
            repeat (3) @(posedge clk_sys_in);
            `CHK(intrq_out, 1'b1)
            rd(3'h4);
            `CHK({r[7:6], r[0]}, {1'b0, ~k[0], k[0]})
            rd(3'h4);
            `CHK(r[6], 1'b1)
            rd(3'h0);
            `CHK(r, e)
            rd(3'h1);
            `CHK(r, done_count_in)
            rd(3'h2);
            `CHK(r, done_sector_in)
            rd(3'h3);
            `CHK(r, {1'b1, l, 2'b10, done_head_in})
        end
        $display("test done: commands");
        pulse(crc_error_in);
        rd(3'h0);
        `CHK(r[7], 1'b1)
        $display("test done: link crc");
        pulse(link_reset_in);
        boot("link reset");
        pm_mode_in = ata_tf_pkg::PM_SLEEP;
        pulse(pm_req_in);
        pulse(link_reset_in);
        boot("sleep wake");
        `CHK(power_mode_out, ata_tf_pkg::PM_STANDBY)
        wr(3'h1, 8'h5A);
        ata_tf_host_model_inst.soft_reset();
        boot("soft reset");
        close_out();
    end
endmodule
bind ata_taskfile_registers ata_tf_checker ata_tf_checker_inst (.*);
